// File: verilog/emu_phy_pkg.sv
package emu_phy_pkg;
  // ==========================================================
  // register addresses
  localparam logic [4:0] ADDR_CONTROL   = 5'h00;
  localparam logic [4:0] ADDR_STATUS    = 5'h01;
  localparam logic [4:0] ADDR_ADVERT    = 5'h04;
  localparam logic [4:0] ADDR_PARTNER   = 5'h05;
  localparam logic [4:0] ADDR_LOCAL     = 5'h10;
  localparam logic [4:0] ADDR_REMOTE    = 5'h11;
  // ==========================================================
  // reset values and fields
  localparam logic [15:0] CONTROL_RST   = 16'h3100;
  localparam logic [15:0] STATUS_RST    = 16'h7809;
  localparam logic [15:0] ADVERT_RST    = 16'h05E1;
  localparam logic [15:0] PARTNER_RST   = 16'h01E0;
  localparam logic [15:0] LOCAL_RST     = 16'h0000;
  localparam logic [15:0] REMOTE_RST    = 16'h0000;
  localparam int          BIT_LOOPBACK  = 14;
  localparam int          BIT_AN_ON     = 12;
  localparam int          BIT_SPEED     = 13;
  localparam int          BIT_DUPLEX    = 8;
  localparam int          BIT_LINK      = 2;
  localparam int          BIT_RFAULT    = 4;
  localparam int          BIT_AN_DONE   = 5;
  localparam int          BIT_MAC_ON    = 0;
  localparam int          NUM_PORTS     = 3;
  // ==========================================================
  // management frame shape
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [5:0]  PREAMBLE_MIN  = 6'h20;
  localparam logic [5:0]  HDR_BITS      = 6'h0E;
  localparam logic [5:0]  FRAME_BITS    = 6'h20;
  localparam logic [4:0]  PHY_ADDR_DEF  = 5'h00;
endpackage : emu_phy_pkg

// File: verilog/mdio_regs_if.sv
interface mdio_regs_if;
  logic        wr;
  logic        rd;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport frame (output wr, output rd, output addr, output wdata, input rdata);
  modport regs  (input wr, input rd, input addr, input wdata, output rdata);
endinterface : mdio_regs_if

// File: verilog/emu_phy_regfile.sv
module emu_phy_regfile (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_link_up,
  input  wire logic        i_fault_evt,
  input  wire logic        i_an_done,
  mdio_regs_if.regs        bus,
  output logic             o_loopback,
  output logic             o_fixed_full,
  output logic             o_fixed_100
);
  logic        loopback_r;
  logic [15:0] remote_r;
  logic        rfault_r;
  logic [15:0] control_w;
  logic [15:0] status_w;

  // ==========================================================
  // writable state
  // control writes masked to the loopback bit, remote word taken whole
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loopback_r <= 1'b0;
    end else if (bus.wr && bus.addr == emu_phy_pkg::ADDR_CONTROL) begin
      loopback_r <= bus.wdata[emu_phy_pkg::BIT_LOOPBACK];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      remote_r <= emu_phy_pkg::REMOTE_RST;
    end else if (bus.wr && bus.addr == emu_phy_pkg::ADDR_REMOTE) begin
      remote_r <= bus.wdata;
    end
  end

  // clear on read, a new fault wins over the clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rfault_r <= 1'b0;
    end else if (i_fault_evt) begin
      rfault_r <= 1'b1;
    end else if (bus.rd && bus.addr == emu_phy_pkg::ADDR_STATUS) begin
      rfault_r <= 1'b0;
    end
  end

  // ==========================================================
  // read view
  always_comb begin
    control_w = emu_phy_pkg::CONTROL_RST;
    control_w[emu_phy_pkg::BIT_LOOPBACK] = loopback_r;
    status_w = emu_phy_pkg::STATUS_RST;
    status_w[emu_phy_pkg::BIT_LINK] = i_link_up;
    status_w[emu_phy_pkg::BIT_RFAULT] = rfault_r;
    status_w[emu_phy_pkg::BIT_AN_DONE] = i_an_done;
  end

  always_comb begin
    case (bus.addr)
      emu_phy_pkg::ADDR_CONTROL: bus.rdata = control_w;
      emu_phy_pkg::ADDR_STATUS:  bus.rdata = status_w;
      emu_phy_pkg::ADDR_ADVERT:  bus.rdata = emu_phy_pkg::ADVERT_RST;
      emu_phy_pkg::ADDR_PARTNER: bus.rdata = emu_phy_pkg::PARTNER_RST;
      emu_phy_pkg::ADDR_LOCAL:   bus.rdata = emu_phy_pkg::LOCAL_RST;
      emu_phy_pkg::ADDR_REMOTE:  bus.rdata = remote_r;
      default:                   bus.rdata = 16'h0000;
    endcase
  end

  // speed mode: with autoneg on, bits 8 and 13 are ignored
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_loopback   <= 1'b0;
      o_fixed_full <= 1'b0;
      o_fixed_100  <= 1'b0;
    end else begin
      o_loopback   <= loopback_r;
      o_fixed_full <= !control_w[emu_phy_pkg::BIT_AN_ON] && control_w[emu_phy_pkg::BIT_DUPLEX];
      o_fixed_100  <= !control_w[emu_phy_pkg::BIT_AN_ON] && control_w[emu_phy_pkg::BIT_SPEED];
    end
  end

  chk_remote_store: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    bus.wr && bus.addr == emu_phy_pkg::ADDR_REMOTE |=> remote_r == $past(bus.wdata))
    else $error("remote word not stored");
  chk_control_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    bus.addr == emu_phy_pkg::ADDR_CONTROL |-> (bus.rdata & 16'hBFFF) == emu_phy_pkg::CONTROL_RST)
    else $error("control fixed bits changed");
  chk_loopback_out: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    bus.wr && bus.addr == emu_phy_pkg::ADDR_CONTROL
    |=> ##1 o_loopback == $past(bus.wdata[emu_phy_pkg::BIT_LOOPBACK], 2))
    else $error("loopback output does not follow write");
  chk_fault_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    bus.rd && bus.addr == emu_phy_pkg::ADDR_STATUS && !i_fault_evt |=> !rfault_r)
    else $error("remote fault not cleared by read");
  chk_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    bus.addr == 5'h02 |-> bus.rdata == 16'h0000)
    else $error("unmapped address not zero");
endmodule : emu_phy_regfile

// File: verilog/emu_phy_mgmt.sv
module emu_phy_mgmt #(
  parameter logic [4:0] PHY_ADDR = emu_phy_pkg::PHY_ADDR_DEF
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_mdc,
  input  wire logic                          i_mdio,
  input  wire logic [emu_phy_pkg::NUM_PORTS-1:0] i_port_mac_control_lsb,
  input  wire logic                          i_remote_fault,
  input  wire logic                          i_an_done_flag,
  output logic                               o_mdio,
  output logic                               o_mdio_oe,
  output logic                               o_loopback,
  output logic                               o_fixed_full,
  output logic                               o_fixed_100
);
  typedef enum {ST_IDLE, ST_HDR, ST_TA, ST_DATA} state_t;

  mdio_regs_if rbus ();

  logic [2:0]  mdc_sync_r;
  logic [1:0]  mdio_sync_r;
  logic        mdc_rise;
  logic        mdc_fall;
  logic        mdio_in;
  state_t      state_r;
  logic [5:0]  cnt_r;
  logic [13:0] hdr_r;
  logic [15:0] shift_r;
  logic        is_read_r;
  logic        mine_r;
  logic [4:0]  reg_addr_r;
  logic        wr_r;
  logic        rd_r;
  logic [emu_phy_pkg::NUM_PORTS-1:0] mac_s1_r;
  logic [emu_phy_pkg::NUM_PORTS-1:0] mac_s2_r;
  logic        link_r;
  logic        fault_s1_r;
  logic        fault_s2_r;
  logic        an_s1_r;
  logic        an_s2_r;

  // the data phase ends on the rise whose count reaches frame bits less this
  localparam logic [5:0] HDR_LEN_PAD = 6'h11;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mdc_sync_r  <= 3'h0;
      mdio_sync_r <= 2'h3;
    end else begin
      mdc_sync_r  <= {mdc_sync_r[1:0], i_mdc};
      mdio_sync_r <= {mdio_sync_r[0], i_mdio};
    end
  end
  // edges judged on stages two and three only
  assign mdc_rise = mdc_sync_r[1] && !mdc_sync_r[2];
  assign mdc_fall = !mdc_sync_r[1] && mdc_sync_r[2];
  assign mdio_in  = mdio_sync_r[1];

  // ==========================================================
  // status inputs, two flops each since they may come from other logic
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mac_s1_r   <= '0;
      mac_s2_r   <= '0;
      fault_s1_r <= 1'b0;
      fault_s2_r <= 1'b0;
      an_s1_r    <= 1'b0;
      an_s2_r    <= 1'b0;
      link_r     <= 1'b0;
    end else begin
      mac_s1_r   <= i_port_mac_control_lsb;
      mac_s2_r   <= mac_s1_r;
      fault_s1_r <= i_remote_fault;
      fault_s2_r <= fault_s1_r;
      an_s1_r    <= i_an_done_flag;
      an_s2_r    <= an_s1_r;
      link_r     <= |mac_s2_r;
    end
  end

  // ==========================================================
  // frame engine: preamble count, header, turnaround, data
  // clause 22 frame
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 6'h00;
      hdr_r      <= 14'h0000;
      shift_r    <= 16'h0000;
      is_read_r  <= 1'b0;
      mine_r     <= 1'b0;
      reg_addr_r <= 5'h00;
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      if (mdc_rise) begin
        case (state_r)
          ST_IDLE: begin
            if (mdio_in) begin
              if (cnt_r != emu_phy_pkg::PREAMBLE_MIN) begin
                cnt_r <= cnt_r + 6'h01;
              end
            end else if (cnt_r == emu_phy_pkg::PREAMBLE_MIN) begin
              // first start bit seen
              hdr_r   <= 14'h0000;
              cnt_r   <= 6'h01;
              state_r <= ST_HDR;
            end else begin
              cnt_r <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_r <= {hdr_r[12:0], mdio_in};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == emu_phy_pkg::HDR_BITS - 6'h01) begin
              // hdr bits: start(1) op(2) phy(5) reg(5) after the first start bit
              // twelve bits shifted so far: start at 11, op at 10:9, phy at 8:4
              is_read_r  <= hdr_r[10:9] == emu_phy_pkg::OP_READ;
              mine_r     <= hdr_r[8:4] == PHY_ADDR && hdr_r[11] &&
                            (hdr_r[10:9] == emu_phy_pkg::OP_READ ||
                             hdr_r[10:9] == emu_phy_pkg::OP_WRITE);
              reg_addr_r <= {hdr_r[3:0], mdio_in};
              state_r    <= ST_TA;
              cnt_r      <= 6'h00;
            end
          end
          ST_TA: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h01) begin
              cnt_r   <= 6'h00;
              state_r <= ST_DATA;
              if (is_read_r && mine_r) begin
                shift_r <= rbus.rdata;
                rd_r    <= 1'b1;
              end
            end
          end
          ST_DATA: begin
            cnt_r <= cnt_r + 6'h01;
            // read words move up one bit per rise, so the next fall drives the next bit
            if (is_read_r) begin
              shift_r <= {shift_r[14:0], 1'b0};
            end else begin
              shift_r <= {shift_r[14:0], mdio_in};
            end
            if (cnt_r == emu_phy_pkg::FRAME_BITS - HDR_LEN_PAD) begin
              state_r <= ST_IDLE;
              cnt_r   <= 6'h00;
              wr_r    <= mine_r && !is_read_r;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            cnt_r   <= 6'h00;
          end
        endcase
      end
    end
  end

  // write data is the full shifted word once the frame ends
  assign rbus.wr    = wr_r;
  assign rbus.rd    = rd_r;
  assign rbus.addr  = reg_addr_r;
  assign rbus.wdata = shift_r;

  // ==========================================================
  // pin driver: change data on mdc fall, so the master samples on rise
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mdio    <= 1'b1;
      o_mdio_oe <= 1'b0;
    end else if (mdc_fall) begin
      if (state_r == ST_TA && cnt_r == 6'h01 && is_read_r && mine_r) begin
        // second turnaround bit driven low
        o_mdio    <= 1'b0;
        o_mdio_oe <= 1'b1;
      end else if (state_r == ST_DATA && is_read_r && mine_r) begin
        o_mdio    <= shift_r[15];
        o_mdio_oe <= 1'b1;
      end else begin
        o_mdio    <= 1'b1;
        o_mdio_oe <= 1'b0;
      end
    end
  end

  emu_phy_regfile u_regs (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_link_up    (link_r),
    .i_fault_evt  (fault_s2_r),
    .i_an_done    (an_s2_r),
    .bus          (rbus),
    .o_loopback   (o_loopback),
    .o_fixed_full (o_fixed_full),
    .o_fixed_100  (o_fixed_100)
  );

  chk_link_follows: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    |mac_s2_r |=> link_r)
    else $error("link flag not set with mac enabled");
  // the pin is let go on the first fall after the frame, not on the last rise
  chk_ta_release: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    state_r == ST_IDLE && mdc_fall |=> !o_mdio_oe)
    else $error("pin driven outside a read frame");
  chk_turn_low: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    mdc_fall && state_r == ST_TA && cnt_r == 6'h01 && is_read_r && mine_r
    |=> o_mdio_oe && !o_mdio)
    else $error("second turnaround bit not driven low");
  chk_read_shift: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    mdc_rise && state_r == ST_DATA && is_read_r
    |=> shift_r[15:1] == $past(shift_r[14:0]))
    else $error("read word not advanced");
  chk_foreign_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    mdc_fall && !mine_r |=> !o_mdio_oe)
    else $error("pin driven for another address");
  chk_write_single: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    rbus.wr |=> !rbus.wr)
    else $error("write strobe longer than one cycle");
  chk_read_strobe: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    rbus.rd |-> is_read_r && mine_r)
    else $error("read strobe outside an own read frame");
  chk_start_seen: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    mdc_rise && state_r == ST_IDLE && !mdio_in && cnt_r == emu_phy_pkg::PREAMBLE_MIN
    |=> state_r == ST_HDR)
    else $error("start bit after preamble not taken");
  chk_no_write_read: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    rbus.wr |-> !is_read_r && mine_r)
    else $error("write strobe on a read frame");
  chk_an_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !an_s2_r |-> !rbus.rdata[emu_phy_pkg::BIT_AN_DONE] || rbus.addr != emu_phy_pkg::ADDR_STATUS)
    else $error("autoneg done shown while clear");
  cov_write: cover property (@(posedge i_sys_clk) rbus.wr);
  cov_read: cover property (@(posedge i_sys_clk) rbus.rd);
  cov_link: cover property (@(posedge i_sys_clk) link_r);
  cov_status_read: cover property (@(posedge i_sys_clk)
    rbus.rd && rbus.addr == emu_phy_pkg::ADDR_STATUS);
  cov_loopback: cover property (@(posedge i_sys_clk) o_loopback);
endmodule : emu_phy_mgmt

// File: tb/mdio_master_model.sv
module mdio_master_model (
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe,
  input  wire logic i_mdio
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // bit level: the clock stands low between frames
  localparam int HALF = 160;
  initial begin
    o_mdc     = 1'b0;
    o_mdio    = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // data changes after the falling edge and holds across the rising edge
  task automatic send_bit(input logic b);
    o_mdio_oe = 1'b1;
    o_mdio    = b;
    #HALF o_mdc = 1'b1;
    #HALF o_mdc = 1'b0;
  endtask : send_bit
  task automatic get_bit(output logic b);
    #HALF b = i_mdio;
    o_mdc = 1'b1;
    #HALF o_mdc = 1'b0;
  endtask : get_bit
  // ==========================================================
  // frame level
  // clause 22 frame, msb first
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] reg_a,
                       input logic [15:0] wd, output logic [15:0] rdat, output logic ta);
    logic [13:0] hdr;
    logic        b;
    hdr  = {2'b01, (rd ? emu_phy_pkg::OP_READ : emu_phy_pkg::OP_WRITE), phy, reg_a};
    rdat = 16'h0000;
    ta   = 1'b1;
    for (int i = 0; i < 32; i++) begin
      send_bit(1'b1);
    end
    for (int i = 13; i >= 0; i--) begin
      send_bit(hdr[i]);
    end
    if (rd) begin
      // line released: pull-up decides until the slave drives
      o_mdio_oe = 1'b0;
      get_bit(b);
      get_bit(ta);
      for (int i = 15; i >= 0; i--) begin
        get_bit(b);
        rdat[i] = b;
      end
    end else begin
      send_bit(1'b1);
      send_bit(1'b0);
      for (int i = 15; i >= 0; i--) begin
        send_bit(wd[i]);
      end
    end
    o_mdio_oe = 1'b0;
    o_mdio    = ~o_mdio;
    #(4 * HALF);
  endtask : frame
endmodule : mdio_master_model

// File: tb/reverse_mode_emulated_phy_regs_tb.sv
module reverse_mode_emulated_phy_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk;
  logic       reset_n;
  logic       mdc;
  logic       m_mdio;
  logic       m_oe;
  logic       d_mdio;
  logic       d_oe;
  logic       mdio_line;
  logic [2:0] mac_on;
  logic       rfault;
  logic       an_done;
  logic       loopback;
  logic       fixed_full;
  logic       fixed_100;
  int         num_errors;
  int         comparisons;
  // ==========================================================
  // wiring: the management line has a pull-up
  assign mdio_line = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);
  emu_phy_mgmt i_dut (
    .i_sys_clk              (sys_clk),
    .i_reset_n              (reset_n),
    .i_mdc                  (mdc),
    .i_mdio                 (mdio_line),
    .i_port_mac_control_lsb (mac_on),
    .i_remote_fault         (rfault),
    .i_an_done_flag         (an_done),
    .o_mdio                 (d_mdio),
    .o_mdio_oe              (d_oe),
    .o_loopback             (loopback),
    .o_fixed_full           (fixed_full),
    .o_fixed_100            (fixed_100)
  );
  mdio_master_model i_master (
    .o_mdc     (mdc),
    .o_mdio    (m_mdio),
    .o_mdio_oe (m_oe),
    .i_mdio    (mdio_line)
  );
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ta;
    // mdc edges land 2 ns after a system clock edge, like every other input
    @(posedge sys_clk);
    #2;
    i_master.frame(1'b1, emu_phy_pkg::PHY_ADDR_DEF, a, 16'h0000, d, ta);
    check({15'h0000, ta}, 16'h0000);
    check(d, exp);
  endtask : rd_chk
  task automatic wr(input logic [4:0] phy, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] unused_d;
    logic        unused_ta;
    @(posedge sys_clk);
    #2;
    i_master.frame(1'b0, phy, a, d, unused_d, unused_ta);
  endtask : wr
  // a read for another address must leave the line to its pull-up
  task automatic t_other_phy;
    logic [15:0] d;
    logic        ta;
    @(posedge sys_clk);
    #2;
    i_master.frame(1'b1, 5'h01, emu_phy_pkg::ADDR_REMOTE, 16'h0000, d, ta);
    check({15'h0000, ta}, 16'h0001);
    check(d, 16'hFFFF);
  endtask : t_other_phy
  // inputs change a fixed 2 ns after the rising edge
  task automatic set_in(input logic [2:0] m, input logic rf, input logic an);
    @(posedge sys_clk);
    #2;
    mac_on  = m;
    rfault  = rf;
    an_done = an;
  endtask : set_in
  task automatic do_reset;
    @(posedge sys_clk);
    #2 reset_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    check({14'h0000, d_oe, d_mdio}, 16'h0001);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : do_reset
  // ==========================================================
  // scenarios
  task automatic t_reset_vals;
    rd_chk(emu_phy_pkg::ADDR_CONTROL, 16'h3100);
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7809);
    rd_chk(emu_phy_pkg::ADDR_ADVERT, 16'h05E1);
    rd_chk(emu_phy_pkg::ADDR_PARTNER, 16'h01E0);
    rd_chk(emu_phy_pkg::ADDR_LOCAL, 16'h0000);
    rd_chk(emu_phy_pkg::ADDR_REMOTE, 16'h0000);
    rd_chk(5'h02, 16'h0000);
    rd_chk(5'h1F, 16'h0000);
    check({13'h0000, loopback, fixed_full, fixed_100}, 16'h0000);
  endtask : t_reset_vals
  task automatic t_writes;
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_CONTROL, 16'hFFFF);
    rd_chk(emu_phy_pkg::ADDR_CONTROL, 16'h7100);
    check({15'h0000, loopback}, 16'h0001);
    check({14'h0000, fixed_full, fixed_100}, 16'h0000);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_CONTROL, 16'h0000);
    rd_chk(emu_phy_pkg::ADDR_CONTROL, 16'h3100);
    check({15'h0000, loopback}, 16'h0000);
    // reserved status bits written as zero
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_STATUS, 16'hF87F);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_ADVERT, 16'hFFFF);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_PARTNER, 16'hFFFF);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_LOCAL, 16'hFFFF);
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7809);
    rd_chk(emu_phy_pkg::ADDR_ADVERT, 16'h05E1);
    rd_chk(emu_phy_pkg::ADDR_PARTNER, 16'h01E0);
    rd_chk(emu_phy_pkg::ADDR_LOCAL, 16'h0000);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_REMOTE, 16'hA5C3);
    rd_chk(emu_phy_pkg::ADDR_REMOTE, 16'hA5C3);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_REMOTE, 16'h5A3C);
    rd_chk(emu_phy_pkg::ADDR_REMOTE, 16'h5A3C);
    // another slave's frame must be ignored
    wr(5'h01, emu_phy_pkg::ADDR_REMOTE, 16'h1234);
    rd_chk(emu_phy_pkg::ADDR_REMOTE, 16'h5A3C);
  endtask : t_writes
  task automatic t_link;
    for (int i = 0; i < 3; i++) begin
      set_in(3'b001 << i, 1'b0, 1'b0);
      rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h780D);
    end
    set_in(3'b000, 1'b0, 1'b1);
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7829);
    set_in(3'b000, 1'b0, 1'b0);
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7809);
  endtask : t_link
  task automatic t_fault;
    set_in(3'b000, 1'b1, 1'b0);
    set_in(3'b000, 1'b0, 1'b0);
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7819);
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7809);
    set_in(3'b000, 1'b1, 1'b0);
    set_in(3'b000, 1'b0, 1'b0);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_REMOTE, 16'hFFFF);
    wr(emu_phy_pkg::PHY_ADDR_DEF, emu_phy_pkg::ADDR_CONTROL, 16'h4000);
    // a second reset in mid-run restores every default
    do_reset();
    rd_chk(emu_phy_pkg::ADDR_STATUS, 16'h7809);
    rd_chk(emu_phy_pkg::ADDR_REMOTE, 16'h0000);
    rd_chk(emu_phy_pkg::ADDR_CONTROL, 16'h3100);
  endtask : t_fault
  // ==========================================================
  // run control
  task automatic final_report;
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    num_errors++;
    final_report();
  end
  initial begin
    num_errors  = 0;
    comparisons = 0;
    reset_n     = 1'b0;
    mac_on      = 3'b000;
    rfault      = 1'b0;
    an_done     = 1'b0;
    do_reset();
    t_reset_vals();
    t_writes();
    t_other_phy();
    t_link();
    t_fault();
    final_report();
  end
endmodule : reverse_mode_emulated_phy_regs_tb
